// ### sysctl_pkg.sv
// Purpose: Shared constants and types for the system reset and clock sequencer
// Assumes: AHB-Lite register access, one word per register, byte address = 4 * index
// Notes:   Register indices keep the printed offsets; bus addresses are four times them
package sysctl_pkg;

  // ---------------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------------
  localparam logic [29:0] IDX_BRK   = 30'h0000fe00;
  localparam logic [29:0] IDX_CAUSE = 30'h0000fe01;
  localparam logic [29:0] IDX_UPPER = 30'h0000fe02;
  localparam logic [29:0] IDX_BFCR  = 30'h0000fe03;
  localparam logic [29:0] IDX_CTRL  = 30'h0000fe04;
  localparam logic [29:0] IDX_IST   = 30'h0000fe05;
  localparam logic [29:0] IDX_IMSK  = 30'h0000fe06;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int CAUSE_POR     = 7;
  localparam int CAUSE_PIN     = 6;
  localparam int CAUSE_WDOG    = 5;
  localparam int CAUSE_BADOP   = 4;
  localparam int CAUSE_BADADDR = 3;
  localparam int CAUSE_MODE    = 2;
  localparam int CAUSE_LVI     = 1;
  localparam logic [7:0] CAUSE_RESET = 8'h80;
  localparam int STOPPED_BY_BREAK_FLAG_BIT       = 1;
  localparam int BREAK_FLAG_CLEAR_ENABLE_BIT       = 7;
  localparam int STOP_SHORT_BIT = 0;
  localparam int IRQ_W          = 4;
  localparam int EV_RESET_DONE  = 0;
  localparam int EV_STOP_DONE   = 1;
  localparam int EV_WAKE        = 2;
  localparam int EV_BREAK       = 3;

  // ---------------------------------------------------------------------------
  // Timing, in reference clock cycles
  // ---------------------------------------------------------------------------
  localparam int CNT_W     = 13;
  localparam int PIN_CNT_W = 7;
  localparam int POR_TIMEOUT_DEF = 4096;
  localparam int STOP_LONG_DEF   = 4096;
  localparam int STOP_SHORT_CYC  = 32;
  localparam int SETTLE_CYC      = 64;
  localparam int SYNC_CYC        = 3;
  localparam logic [CNT_W-1:0] RECOVERY_SHORT = CNT_W'(SETTLE_CYC + SYNC_CYC);
  localparam logic [PIN_CNT_W-1:0] PIN_MIN    = PIN_CNT_W'(SETTLE_CYC + SYNC_CYC);
  localparam logic [PIN_CNT_W-1:0] PIN_SAT    = '1;
  localparam logic [1:0] BUS_TICK = 2'h3;

  // ---------------------------------------------------------------------------
  // Vectors and bus codes
  // ---------------------------------------------------------------------------
  localparam logic [15:0] VEC_USER    = 16'hfffe;
  localparam logic [15:0] VEC_MONITOR = 16'hfefe;
  localparam logic [2:0]  SIZE_WORD   = 3'h2;
  localparam int          HTRANS_ACT  = 1;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR_WAIT, ST_RECOVER, ST_PIN_HOLD, ST_PIN_REC, ST_RUN, ST_WAIT, ST_STOP, ST_STOP_EXIT
  } state_e;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_BRK, SEL_CAUSE, SEL_UPPER, SEL_BFCR, SEL_CTRL, SEL_IST, SEL_IMSK
  } sel_e;

  typedef struct packed {
    logic por;
    logic low_voltage_cause;
    logic wdog;
    logic bad_op;
    logic bad_addr;
    logic mode_entry;
  } rst_src_s;

  typedef struct packed {
    logic cpu;
    logic periph;
  } clk_en_s;

endpackage : sysctl_pkg

// ### bus_clock_div.sv
// Purpose: Divides the reference clock into the generator output and bus clock phases
// Assumes: CLK_I stands for whichever source the clock generator selected
// Notes:   Clock enables are one-cycle ticks, one per bus cycle
`timescale 1ns/1ps
module bus_clock_div
  import sysctl_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    nrst_i,
  input  wire clk_en_s run_i,
  output logic         gen_clk_o,
  output logic         bus_clk_o,
  output clk_en_s      tick_o
);

  typedef struct packed {
    logic [1:0] div;
    clk_en_s    tick;
  } div_s;

  div_s r;
  div_s n;

  // ---------------------------------------------------------------------------
  // Divide by two for the generator output, by two again for the bus
  // ---------------------------------------------------------------------------
  always_comb begin
    n          = r;
    n.div      = r.div + 2'h1;
    n.tick.cpu = run_i.cpu && (r.div == BUS_TICK);
    n.tick.periph = run_i.periph && (r.div == BUS_TICK);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign gen_clk_o = r.div[0];
  assign bus_clk_o = r.div[1];
  assign tick_o    = r.tick;

endmodule : bus_clock_div

// ### sysctl_top.sv
// Purpose: Reset, stop, wait and break sequencing with reset cause and break status
// Assumes: CLK_I is the oscillator reference clock; reset sources are same-clock levels
// Notes:   Reset pin is open drain: output low while enabled
// What this block does
// - The bus runs at a quarter of the selected reference or PLL clock.
// - The bus clock is the clock generator output divided by two.
// - After power-on or low voltage, clocks stay off through a 4096-cycle timeout.
// - The reset pin is driven low for the whole power-on timeout.
// - Leaving stop, the counter runs on the reference clock and clocks stay off until done.
// - The stop-exit delay is selectable as 4096 or 32 cycles.
// - In wait the CPU clock stops while peripheral clocks keep running.
// - Every reset fetches the top vector, or the alternate one in monitor mode.
// - Any reset source asserts the internal reset to return the chip to defaults.
// - Internal resets clear the delay counter; a pin reset leaves it alone.
// - The cause register holds one read-only bit per source and reads 0x80 after power-on.
// - Holding the external reset pin low halts all processing.
// - The pin cause bit sets only after 67 low cycles and not for power-on or low voltage.
// - Recovery lasts 4163 cycles after power-on or low voltage and 67 otherwise.
// - The break status register holds the stopped-by-break flag, cleared by writing 0.
// - Modules may clear status bits in break only when the clear enable bit is set.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sysctl_top
  import sysctl_pkg::*;
#(
  parameter int POR_TIMEOUT_CYC = POR_TIMEOUT_DEF,
  parameter int STOP_LONG_CYC   = STOP_LONG_DEF
)(
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire rst_src_s    RST_SRC_I,
  input  wire logic        RST_PIN_I,
  output logic             RST_PIN_O,
  output logic             RST_PIN_OE_O,
  input  wire logic        MONITOR_I,
  input  wire logic        WAIT_REQ_I,
  input  wire logic        STOP_REQ_I,
  input  wire logic        WAKE_I,
  input  wire logic        BREAK_I,
  output logic             INTERNAL_RESET_O,
  output logic             VEC_FETCH_O,
  output logic [15:0]      VEC_ADDR_O,
  output clk_en_s          CLK_EN_O,
  output logic             GEN_CLK_O,
  output logic             BUS_CLK_O,
  output logic             CLEAR_ALLOWED_O,
  output logic             IRQ_O
);

  localparam logic [CNT_W-1:0] POR_END   = CNT_W'(POR_TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] LONG_END  = CNT_W'(POR_TIMEOUT_CYC - 1) + RECOVERY_SHORT;
  localparam logic [CNT_W-1:0] SHORT_END = RECOVERY_SHORT - CNT_W'(1);
  localparam logic [CNT_W-1:0] STOPL_END = CNT_W'(STOP_LONG_CYC - 1);
  localparam logic [CNT_W-1:0] STOPS_END = CNT_W'(STOP_SHORT_CYC - 1);

  typedef struct packed {
    state_e               st;
    logic [CNT_W-1:0]     cnt;
    logic [PIN_CNT_W-1:0] pin_cnt;
    logic [2:0]           sync;
    logic                 pin_low;
    logic                 ign_pin;
    logic                 long_rec;
    logic                 vec;
    logic [15:0]          vaddr;
    logic [7:0]           cause;
    logic                 stopped_by_break_flag;
    logic                 break_flag_clear_enable;
    logic                 stop_short;
    logic [IRQ_W-1:0]     ist;
    logic [IRQ_W-1:0]     imsk;
    logic                 wr_pend;
    sel_e                 wsel;
    logic [31:0]          rdata;
  } core_s;

  localparam core_s CORE_RESET = '{
    st: ST_POR_WAIT, cnt: '0, pin_cnt: '0, sync: 3'h7, pin_low: 1'b0, ign_pin: 1'b1,
    long_rec: 1'b1, vec: 1'b0, vaddr: VEC_USER, cause: CAUSE_RESET, stopped_by_break_flag: 1'b0,
    break_flag_clear_enable: 1'b0, stop_short: 1'b0, ist: '0, imsk: '0, wr_pend: 1'b0, wsel: SEL_NONE,
    rdata: '0};

  core_s r;
  core_s n;

  // ---------------------------------------------------------------------------
  // Address decode and read mux
  // ---------------------------------------------------------------------------
  function automatic sel_e decode(input logic [31:0] addr);
    if (addr[1:0] != 2'h0) decode = SEL_NONE;
    else if (addr[31:2] == IDX_BRK) decode = SEL_BRK;
    else if (addr[31:2] == IDX_CAUSE) decode = SEL_CAUSE;
    else if (addr[31:2] == IDX_UPPER) decode = SEL_UPPER;
    else if (addr[31:2] == IDX_BFCR) decode = SEL_BFCR;
    else if (addr[31:2] == IDX_CTRL) decode = SEL_CTRL;
    else if (addr[31:2] == IDX_IST) decode = SEL_IST;
    else if (addr[31:2] == IDX_IMSK) decode = SEL_IMSK;
    else decode = SEL_NONE;
  endfunction : decode

  function automatic logic [7:0] cause_of(input rst_src_s s);
    cause_of                = '0;
    cause_of[CAUSE_POR]     = s.por;
    cause_of[CAUSE_LVI]     = s.low_voltage_cause;
    cause_of[CAUSE_WDOG]    = s.wdog;
    cause_of[CAUSE_BADOP]   = s.bad_op;
    cause_of[CAUSE_BADADDR] = s.bad_addr;
    cause_of[CAUSE_MODE]    = s.mode_entry;
  endfunction : cause_of

  logic             acc;
  logic             src_long;
  logic             src_short;
  logic             stopped_by_break_flag_set;
  logic             stopped_by_break_flag_clr;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] ist_clr;
  logic [7:0]       rd_byte;

  assign acc       = HSEL_I && HREADY_I && HTRANS_I[HTRANS_ACT];
  assign src_long  = RST_SRC_I.por || RST_SRC_I.low_voltage_cause;
  assign src_short = RST_SRC_I.wdog || RST_SRC_I.bad_op || RST_SRC_I.bad_addr ||
                     RST_SRC_I.mode_entry;

  always_comb begin
    rd_byte = '0;
    case (decode(HADDR_I))
      SEL_BRK:  rd_byte[STOPPED_BY_BREAK_FLAG_BIT] = r.stopped_by_break_flag;
      SEL_CAUSE: rd_byte = r.cause;
      SEL_BFCR: rd_byte[BREAK_FLAG_CLEAR_ENABLE_BIT] = r.break_flag_clear_enable;
      SEL_CTRL: rd_byte[STOP_SHORT_BIT] = r.stop_short;
      SEL_IST:  rd_byte[IRQ_W-1:0] = r.ist;
      SEL_IMSK: rd_byte[IRQ_W-1:0] = r.imsk;
      default:  rd_byte = '0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sequencer and registers
  // ---------------------------------------------------------------------------
  always_comb begin
    n        = r;
    n.vec    = 1'b0;
    ev       = '0;
    stopped_by_break_flag_set = 1'b0;
    stopped_by_break_flag_clr = 1'b0;
    ist_clr  = '0;
    n.vaddr  = MONITOR_I ? VEC_MONITOR : VEC_USER;

    // Reset pin filter: a level counts once the last two stages agree
    n.sync = {r.sync[1:0], RST_PIN_I};
    if (r.sync[1] == r.sync[2]) begin
      n.pin_low = ~r.sync[2];
    end
    if (!r.pin_low) begin
      n.ign_pin = 1'b0;
    end

    // Bus address phase
    n.wr_pend = acc && HWRITE_I && (HSIZE_I == SIZE_WORD);
    n.wsel    = decode(HADDR_I);
    if (acc && !HWRITE_I) begin
      n.rdata = {24'h000000, rd_byte};
    end

    // Bus data phase
    if (r.wr_pend) begin
      case (r.wsel)
        SEL_BRK:  stopped_by_break_flag_clr = !HWDATA_I[STOPPED_BY_BREAK_FLAG_BIT];
        SEL_BFCR: n.break_flag_clear_enable = HWDATA_I[BREAK_FLAG_CLEAR_ENABLE_BIT];
        SEL_CTRL: n.stop_short = HWDATA_I[STOP_SHORT_BIT];
        SEL_IST:  ist_clr = HWDATA_I[IRQ_W-1:0];
        SEL_IMSK: n.imsk = HWDATA_I[IRQ_W-1:0];
        default:  ist_clr = '0;
      endcase
    end

    case (r.st)
      ST_POR_WAIT: begin
        n.ign_pin = 1'b1;
        n.cnt     = r.cnt + CNT_W'(1);
        if (r.cnt == POR_END) begin
          n.st = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        n.ign_pin = 1'b1;
        if (r.cnt == (r.long_rec ? LONG_END : SHORT_END)) begin
          n.st  = ST_RUN;
          n.vec = 1'b1;
          ev[EV_RESET_DONE] = 1'b1;
        end else begin
          n.cnt = r.cnt + CNT_W'(1);
        end
      end
      ST_PIN_HOLD: begin
        if (r.pin_cnt != PIN_SAT) begin
          n.pin_cnt = r.pin_cnt + PIN_CNT_W'(1);
        end
        if (!r.pin_low) begin
          if (r.pin_cnt >= PIN_MIN) begin
            n.cause = '0;
            n.cause[CAUSE_PIN] = 1'b1;
          end
          n.st      = ST_PIN_REC;
          n.pin_cnt = '0;
        end
      end
      ST_PIN_REC: begin
        if (r.pin_cnt == PIN_MIN - PIN_CNT_W'(1)) begin
          n.st  = ST_RUN;
          n.vec = 1'b1;
          ev[EV_RESET_DONE] = 1'b1;
        end else begin
          n.pin_cnt = r.pin_cnt + PIN_CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (STOP_REQ_I) begin
          n.st = ST_STOP;
        end else if (WAIT_REQ_I) begin
          n.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (BREAK_I) begin
          n.st = ST_RUN;
          stopped_by_break_flag_set = 1'b1;
          ev[EV_BREAK] = 1'b1;
        end else if (WAKE_I) begin
          n.st = ST_RUN;
          ev[EV_WAKE] = 1'b1;
        end
      end
      ST_STOP: begin
        if (BREAK_I || WAKE_I) begin
          n.st  = ST_STOP_EXIT;
          n.cnt = '0;
          stopped_by_break_flag_set = BREAK_I;
          ev[EV_BREAK] = BREAK_I;
        end
      end
      ST_STOP_EXIT: begin
        if (r.cnt == (r.stop_short ? STOPS_END : STOPL_END)) begin
          n.st = ST_RUN;
          ev[EV_STOP_DONE] = 1'b1;
        end else begin
          n.cnt = r.cnt + CNT_W'(1);
        end
      end
      default: n.st = ST_POR_WAIT;
    endcase

    // Reset sources take over from any state
    if (src_long || src_short) begin
      n.st       = src_long ? ST_POR_WAIT : ST_RECOVER;
      n.long_rec = src_long;
      n.cnt      = '0;
      n.cause    = cause_of(RST_SRC_I);
      n.ign_pin  = 1'b1;
    end else if (r.pin_low && !r.ign_pin && (r.st != ST_PIN_HOLD)) begin
      n.st      = ST_PIN_HOLD;
      n.pin_cnt = '0;
    end
    if (n.st != r.st && (n.st == ST_POR_WAIT || n.st == ST_RECOVER ||
                         n.st == ST_PIN_HOLD)) begin
      n.break_flag_clear_enable       = 1'b0;
      n.stop_short = 1'b0;
      n.imsk       = '0;
      stopped_by_break_flag_set     = 1'b0;
      stopped_by_break_flag_clr     = 1'b1;
    end

    n.stopped_by_break_flag = stopped_by_break_flag_set || (r.stopped_by_break_flag && !stopped_by_break_flag_clr);
    n.ist  = ev | (r.ist & ~ist_clr);
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      r <= CORE_RESET;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock gating and outputs
  // ---------------------------------------------------------------------------
  clk_en_s run_en;

  assign run_en.cpu    = (r.st == ST_RUN);
  assign run_en.periph = (r.st == ST_RUN) || (r.st == ST_WAIT);

  bus_clock_div i_bus_clock_div (
    .clk_i     (CLK_I),
    .nrst_i    (NRST_I),
    .run_i     (run_en),
    .gen_clk_o (GEN_CLK_O),
    .bus_clk_o (BUS_CLK_O),
    .tick_o    (CLK_EN_O)
  );

  assign INTERNAL_RESET_O = (r.st == ST_POR_WAIT) || (r.st == ST_RECOVER) ||
                            (r.st == ST_PIN_HOLD) || (r.st == ST_PIN_REC);
  assign RST_PIN_OE_O     = (r.st == ST_POR_WAIT) || (r.st == ST_RECOVER);
  assign RST_PIN_O        = 1'b0;
  assign VEC_FETCH_O      = r.vec;
  assign VEC_ADDR_O       = r.vaddr;
  assign CLEAR_ALLOWED_O  = !BREAK_I || r.break_flag_clear_enable;
  assign IRQ_O            = |(r.ist & r.imsk);
  assign HRDATA_O         = r.rdata;
  assign HREADYOUT_O      = 1'b1;
  assign HRESP_O          = 1'b0;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_pin_drive;
    @(posedge CLK_I) disable iff (!NRST_I)
    (r.st == ST_POR_WAIT) |-> (RST_PIN_OE_O && !RST_PIN_O && INTERNAL_RESET_O);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven in timeout");

  property p_por_clocks;
    @(posedge CLK_I) disable iff (!NRST_I)
    (r.st == ST_POR_WAIT) |=> (CLK_EN_O == '0);
  endproperty
  a_por_clocks: assert property (p_por_clocks) else $error("clock tick in timeout");

  property p_stop_clocks;
    @(posedge CLK_I) disable iff (!NRST_I)
    (r.st == ST_STOP_EXIT) ##1 (r.st == ST_STOP_EXIT) |-> (CLK_EN_O == '0);
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("clock tick in stop delay");

  property p_wait_clocks;
    @(posedge CLK_I) disable iff (!NRST_I)
    (r.st == ST_WAIT) [*2] |-> !CLK_EN_O.cpu;
  endproperty
  a_wait_clocks: assert property (p_wait_clocks) else $error("cpu tick in wait");

  property p_stop_short;
    @(posedge CLK_I) disable iff (!NRST_I || src_long || src_short || r.pin_low)
    $rose(r.st == ST_STOP_EXIT) && r.stop_short |-> ##32 (r.st == ST_RUN);
  endproperty
  a_stop_short: assert property (p_stop_short) else $error("short stop delay wrong");

  property p_short_rec;
    @(posedge CLK_I) disable iff (!NRST_I)
    (RST_SRC_I.wdog && !src_long) ##1 (!src_long && !src_short) [*8]
      |-> ##59 (r.st == ST_RECOVER) ##1 (r.st == ST_RUN);
  endproperty
  a_short_rec: assert property (p_short_rec) else $error("short recovery not 67");

  property p_reset_in;
    @(posedge CLK_I) disable iff (!NRST_I)
    (src_long || src_short) |=> INTERNAL_RESET_O ##0 (r.cnt == '0);
  endproperty
  a_reset_in: assert property (p_reset_in) else $error("source did not reset");

  property p_cause_por;
    @(posedge CLK_I) disable iff (!NRST_I)
    (RST_SRC_I == rst_src_s'(6'h20)) |=> (r.cause == CAUSE_RESET);
  endproperty
  a_cause_por: assert property (p_cause_por) else $error("cause not 0x80 after por");

  property p_pin_cause;
    @(posedge CLK_I) disable iff (!NRST_I)
    $rose(r.cause[CAUSE_PIN]) |-> ($past(r.pin_cnt) >= PIN_MIN) && !r.cause[CAUSE_POR];
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin cause on short pulse");

  property p_release;
    @(posedge CLK_I) disable iff (!NRST_I)
    $fell(INTERNAL_RESET_O) |-> VEC_FETCH_O && !RST_PIN_OE_O &&
      (VEC_ADDR_O == ($past(MONITOR_I) ? VEC_MONITOR : VEC_USER));
  endproperty
  a_release: assert property (p_release) else $error("no vector fetch at release");

endmodule : sysctl_top

// ### rst_pin_model.sv
// Purpose: Outside party on the reset pin, with the pin's pullup
// Assumes: One low request at a time; the device only ever pulls the pin low
// Notes:   Pin reads high unless the device or this model pulls it
`timescale 1ns/1ps
module rst_pin_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] len_i,
  input  wire logic       dev_oe_i,
  output logic            pin_o
);
  logic [7:0] cnt_r = 8'h00;
  always_ff @(posedge clk_i) begin
    cnt_r <= start_i ? len_i : cnt_r - 8'(cnt_r != 8'h00);
  end
  assign pin_o = !(dev_oe_i || cnt_r != 8'h00);
endmodule : rst_pin_model

// ### tb_system_reset_clock_sequencer.sv
// Purpose: Self-checking bench for the reset and clock sequencer
// Assumes: Counts shortened to 16 cycles through the top parameters
// Notes:   Sampling is done 1 ns after the rising edge
`timescale 1ns/1ps
module tb_system_reset_clock_sequencer;
  import sysctl_pkg::*;
  logic clk = 0, nrst = 0, hsel = 0, hwr = 0, mon = 0, wreq = 0, sreq = 0, wake = 0, brk = 0;
  logic pstart = 0, pin, oe, po, ir, ir0, vf, hrdy, hresp, gclk, bclk, clr, irq;
  logic [1:0] htr = 2'h0;
  logic [2:0] hsz = SIZE_WORD;
  logic [31:0] haddr = 32'h0, hwd = 32'h0, hrd, rd;
  logic [7:0] plen = 8'h00;
  logic [7:0] cexp [6] = '{8'h80, 8'h02, 8'h20, 8'h10, 8'h08, 8'h04};
  logic [15:0] va;
  rst_src_s src = '0;
  clk_en_s ce;
  int fails = 0, checks_done = 0, n, nc, np, nb, ng;

  sysctl_top #(.POR_TIMEOUT_CYC(16), .STOP_LONG_CYC(16)) i_sysctl_top (
    .CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htr),
    .HWRITE_I(hwr), .HSIZE_I(hsz), .HWDATA_I(hwd), .HREADY_I(hrdy), .HRDATA_O(hrd),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .RST_SRC_I(src), .RST_PIN_I(pin), .RST_PIN_O(po),
    .RST_PIN_OE_O(oe), .MONITOR_I(mon), .WAIT_REQ_I(wreq), .STOP_REQ_I(sreq), .WAKE_I(wake),
    .BREAK_I(brk), .INTERNAL_RESET_O(ir), .VEC_FETCH_O(vf), .VEC_ADDR_O(va), .CLK_EN_O(ce),
    .GEN_CLK_O(gclk), .BUS_CLK_O(bclk), .CLEAR_ALLOWED_O(clr), .IRQ_O(irq));
  rst_pin_model i_rst_pin_model (.clk_i(clk), .start_i(pstart), .len_i(plen),
    .dev_oe_i(oe), .pin_o(pin));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [29:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htr <= 2'h2;
    hwr <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrd;
  endtask : bus
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // Counts edges up to the vector fetch pulse
  task automatic fetch();
    n = 0;
    do begin
      cyc(1);
      n++;
      if (n == 1) ir0 = ir;
    end while (vf !== 1'b1 && n < 6000);
  endtask : fetch
  task automatic fire(input rst_src_s s, input logic m);
    @(posedge clk);
    src <= s;
    mon <= m;
    @(posedge clk);
    src <= '0;
  endtask : fire
  task automatic pull(input logic [7:0] len);
    @(posedge clk);
    pstart <= 1'b1;
    plen <= len;
    @(posedge clk);
    pstart <= 1'b0;
    fetch();
    bus(1'b0, IDX_CAUSE, 32'h0);
  endtask : pull
  // Tick and toggle counts over 16 cycles
  task automatic count16();
    logic bp, gp;
    nc = 0;
    np = 0;
    nb = 0;
    ng = 0;
    bp = bclk;
    gp = gclk;
    repeat (16) begin
      cyc(1);
      nc += int'(ce.cpu === 1'b1);
      np += int'(ce.periph === 1'b1);
      nb += int'(bclk !== bp);
      ng += int'(gclk !== gp);
      bp = bclk;
      gp = gclk;
    end
  endtask : count16
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial forever #2.5 clk = ~clk;
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    cyc(10);
    chk(32'({oe, ir, po, hresp}), 32'hc);
    fetch();
    chk(32'(n), 32'd73);
    chk(32'({oe, ir, va}), 32'(VEC_USER));
    bus(1'b1, IDX_CAUSE, 32'hff);
    bus(1'b0, IDX_CAUSE, 32'h0);
    chk(rd, 32'(CAUSE_RESET));
    bus(1'b1, IDX_UPPER, 32'hff);
    bus(1'b0, IDX_UPPER, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 30'h100, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      fire(rst_src_s'(6'h20 >> i), i[0]);
      fetch();
      chk(32'(n), (i < 2) ? 32'd83 : 32'd67);
      chk(32'({ir0, va}), {16'h0001, i[0] ? VEC_MONITOR : VEC_USER});
      bus(1'b0, IDX_CAUSE, 32'h0);
      chk(rd, 32'(cexp[i]));
    end
    pull(8'd20);
    chk(rd, 32'h04);
    pull(8'd80);
    chk(rd, 32'h40);
    @(posedge clk);
    wreq <= 1'b1;
    @(posedge clk);
    wreq <= 1'b0;
    cyc(2);
    count16();
    chk(32'({nc[7:0], np[7:0], nb[7:0], ng[7:0]}), 32'h00040810);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    cyc(2);
    count16();
    chk(32'(nc), 32'd4);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, IDX_CTRL, 32'(j == 0));
      @(posedge clk);
      sreq <= 1'b1;
      @(posedge clk);
      sreq <= 1'b0;
      count16();
      chk(32'(np + nc), 32'd0);
      @(posedge clk);
      brk <= 1'b1;
      n = 0;
      do begin
        cyc(1);
        n++;
      end while (ce.cpu !== 1'b1 && n < 9000);
      nc = (j == 0) ? 32 : 16;
      chk(32'(n > nc && n <= nc + 8), 32'h1);
      chk(32'(clr), 32'h0);
      bus(1'b0, IDX_BRK, 32'h0);
      chk(rd, 32'h2);
      bus(1'b1, IDX_BFCR, 32'h80);
      cyc(1);
      chk(32'(clr), 32'h1);
      @(posedge clk);
      brk <= 1'b0;
      bus(1'b1, IDX_BRK, 32'h0);
      bus(1'b0, IDX_BRK, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, IDX_BFCR, 32'h0);
    end
    bus(1'b0, IDX_IST, 32'h0);
    chk(rd, 32'hf);
    chk(32'(irq), 32'h0);
    bus(1'b1, IDX_IMSK, 32'h2);
    cyc(1);
    chk(32'(irq), 32'h1);
    bus(1'b1, IDX_IST, 32'h2);
    cyc(1);
    chk(32'(irq), 32'h0);
    bus(1'b0, IDX_IST, 32'h0);
    chk(rd, 32'hd);
    hsz <= 3'h0;
    bus(1'b1, IDX_IMSK, 32'hf);
    hsz <= SIZE_WORD;
    bus(1'b0, IDX_IMSK, 32'h0);
    chk(rd, 32'h2);
    report_and_stop();
  end
endmodule : tb_system_reset_clock_sequencer
